// >>> verilog/mhra_top.sv
/*
  Host register access of a four-axis motion controller: samples the
  parallel host bus, decodes word and byte reads onto the status, I/O
  and data read registers, and assembles command and register writes.
  Assumes host pins are asynchronous and status inputs are on clock.
*/
`timescale 1ns/1ns
`default_nettype none

module mhra_top (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic host_cs_n,
    input wire logic host_rd_n,
    input wire logic host_wr_n,
    input wire logic bus8_mode,
    input wire logic [3:0] host_addr,
    input wire logic [15:0] host_data_in,
    output logic [15:0] host_data_out,
    output logic host_data_oe,
    input wire logic [15:0] main_status,
    input wire mhra_pkg::mhra_axis_status_s [3:0] axis_status,
    input wire logic [15:0] gpio_xy,
    input wire logic [15:0] gpio_zu,
    input wire logic [31:0] data_read_value,
    output logic command_strobe,
    output logic [7:0] command_code,
    output logic [3:0] command_axes,
    output logic reg_write_strobe,
    output logic [2:0] reg_write_index,
    output logic [15:0] reg_write_data,
    output logic [1:0] reg_write_bytes,
    output logic paged_status_page,
    output logic [3:0] selected_axes
);
    import mhra_pkg::*;

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------

    logic [PIN_WIDTH-1:0] pins_q;
    mhra_pins_s pins;
    logic rd_active;
    logic wr_active;

    mhra_sync2 #(
        .WIDTH(PIN_WIDTH),
        .RST_VALUE(PINS_RST)
    ) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .d({host_cs_n, host_rd_n, host_wr_n, bus8_mode, host_addr,
            host_data_in}),
        .q(pins_q)
    );

    assign pins = mhra_pins_s'(pins_q);
    assign rd_active = !pins.cs_n && !pins.rd_n;
    assign wr_active = !pins.cs_n && !pins.wr_n;

    // ------------------------------------------------------------
    // Write capture
    // ------------------------------------------------------------

    logic wr_active_d;
    logic hold_bus8;
    logic [3:0] hold_addr;
    logic [15:0] hold_data;
    logic wr_done;
    logic [2:0] wr_index;
    logic wr_upper;

    // The last sample taken while the strobe is low is the one used.
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            wr_active_d <= 1'b0;
            hold_bus8 <= 1'b0;
            hold_addr <= 4'h0;
            hold_data <= 16'h0000;
        end
        else
        begin
            wr_active_d <= wr_active;
            if (wr_active)
            begin
                hold_bus8 <= pins.bus8;
                hold_addr <= pins.addr;
                hold_data <= pins.data;
            end
        end
    end

    assign wr_done = wr_active_d && !wr_active;
    assign wr_index = hold_bus8 ? hold_addr[3:1] : hold_addr[2:0];
    assign wr_upper = hold_bus8 && hold_addr[0];

    // ------------------------------------------------------------
    // Command register
    // ------------------------------------------------------------

    logic [7:0] cmd_upper;
    logic cmd_fire;
    logic [15:0] next_cmd_word;

    assign cmd_fire = wr_done && (wr_index == IDX_CMD) && !wr_upper;
    assign next_cmd_word = hold_bus8 ? {cmd_upper, hold_data[7:0]}
                                     : hold_data;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            cmd_upper <= CMD_UPPER_RST;
        end
        else if (wr_done && (wr_index == IDX_CMD) && wr_upper)
        begin
            cmd_upper <= hold_data[7:0];
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            command_strobe <= 1'b0;
            command_code <= 8'h00;
            command_axes <= 4'h0;
        end
        else
        begin
            command_strobe <= cmd_fire;
            if (cmd_fire)
            begin
                command_code <= next_cmd_word[CMD_CODE_LSB +: 8];
                command_axes <= next_cmd_word[CMD_AXES_LSB +: AXES];
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            selected_axes <= AXIS_SEL_RST;
        end
        else if (cmd_fire && (next_cmd_word[CMD_AXES_LSB +: AXES] != 4'h0))
        begin
            selected_axes <= next_cmd_word[CMD_AXES_LSB +: AXES];
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            paged_status_page <= PAGE_RST;
        end
        else if (cmd_fire)
        begin
            if (next_cmd_word[CMD_CODE_LSB +: 8] == CMD_PAGE0)
            begin
                paged_status_page <= 1'b0;
            end
            else if (next_cmd_word[CMD_CODE_LSB +: 8] == CMD_PAGE1)
            begin
                paged_status_page <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Other register writes
    // ------------------------------------------------------------

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            reg_write_strobe <= 1'b0;
            reg_write_index <= 3'h0;
            reg_write_data <= 16'h0000;
            reg_write_bytes <= 2'h0;
        end
        else
        begin
            reg_write_strobe <= wr_done && (wr_index != IDX_CMD);
            if (wr_done && (wr_index != IDX_CMD))
            begin
                reg_write_index <= wr_index;
                if (hold_bus8)
                begin
                    reg_write_data <= {hold_data[7:0], hold_data[7:0]};
                    reg_write_bytes <= wr_upper ? LANE_HIGH : LANE_LOW;
                end
                else
                begin
                    reg_write_data <= hold_data;
                    reg_write_bytes <= LANE_BOTH;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------

    logic [1:0] pick_index;
    mhra_axis_status_s picked;
    logic [2:0] rd_index;
    logic [15:0] rd_word;
    logic [15:0] next_data_out;

    mhra_axis_pick u_pick (
        .axes(selected_axes),
        .status(axis_status),
        .axis_index(pick_index),
        .picked(picked)
    );

    assign rd_index = pins.bus8 ? pins.addr[3:1] : pins.addr[2:0];

    always_comb
    begin
        unique case (rd_index)
            IDX_MAIN: rd_word = main_status;
            IDX_IRQ: rd_word = picked.irq;
            IDX_ERR: rd_word = picked.err_finish;
            IDX_PAGED: rd_word = paged_status_page ? picked.s3_page1
                                                   : picked.s3_page0;
            IDX_GPIO_XY: rd_word = gpio_xy;
            IDX_GPIO_ZU: rd_word = gpio_zu;
            IDX_DATA_LO: rd_word = data_read_value[15:0];
            IDX_DATA_HI: rd_word = data_read_value[31:16];
        endcase
        if (!pins.bus8)
        begin
            next_data_out = rd_word;
        end
        else if (pins.addr[0])
        begin
            next_data_out = {8'h00, rd_word[15:8]};
        end
        else
        begin
            next_data_out = {8'h00, rd_word[7:0]};
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            host_data_out <= 16'h0000;
            host_data_oe <= 1'b0;
        end
        else
        begin
            host_data_out <= rd_active ? next_data_out : 16'h0000;
            host_data_oe <= rd_active;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    sequence s_word_read(logic [2:0] idx);
        rd_active && !pins.bus8 && (rd_index == idx);
    endsequence

    sequence s_upper_write;
        wr_done && hold_bus8 && (hold_addr == 4'h1);
    endsequence

    sequence s_lower_write;
        wr_done && hold_bus8 && (hold_addr == 4'h0);
    endsequence

    property p_main;
        s_word_read(IDX_MAIN) |=> host_data_oe
            && (host_data_out == $past(main_status));
    endproperty
    a_main: assert property (p_main)
        else $error("main status read mismatch");

    property p_irq;
        s_word_read(IDX_IRQ) |=> host_data_out == $past(picked.irq);
    endproperty
    a_irq: assert property (p_irq)
        else $error("axis interrupt status read mismatch");

    property p_err;
        s_word_read(IDX_ERR) |=> host_data_out == $past(picked.err_finish);
    endproperty
    a_err: assert property (p_err)
        else $error("axis error status read mismatch");

    property p_page0;
        s_word_read(IDX_PAGED) && !paged_status_page
            |=> host_data_out == $past(picked.s3_page0);
    endproperty
    a_page0: assert property (p_page0)
        else $error("paged status page 0 read mismatch");

    property p_page1;
        s_word_read(IDX_PAGED) && paged_status_page
            |=> host_data_out == $past(picked.s3_page1);
    endproperty
    a_page1: assert property (p_page1)
        else $error("paged status page 1 read mismatch");

    property p_page_cmd;
        command_strobe |-> ((command_code != CMD_PAGE0) || !paged_status_page)
            && ((command_code != CMD_PAGE1) || paged_status_page);
    endproperty
    a_page_cmd: assert property (p_page_cmd)
        else $error("page display command not applied");

    property p_page_reset;
        @(posedge clock) disable iff (1'b0)
            sys_rst |=> !paged_status_page;
    endproperty
    a_page_reset: assert property (p_page_reset)
        else $error("page not zero after reset");

    property p_gpio;
        s_word_read(IDX_GPIO_ZU) |=> host_data_out == $past(gpio_zu);
    endproperty
    a_gpio: assert property (p_gpio)
        else $error("general I/O read mismatch");

    property p_data_hi;
        s_word_read(IDX_DATA_HI)
            |=> host_data_out == $past(data_read_value[31:16]);
    endproperty
    a_data_hi: assert property (p_data_hi)
        else $error("data read high word mismatch");

    property p_steer;
        command_strobe && (command_axes != 4'h0)
            |-> selected_axes == command_axes;
    endproperty
    a_steer: assert property (p_steer)
        else $error("axis selection not taken from command");

    property p_byte_high;
        rd_active && pins.bus8 && pins.addr[0]
            |=> host_data_out == {8'h00, $past(rd_word[15:8])};
    endproperty
    a_byte_high: assert property (p_byte_high)
        else $error("byte mode upper byte read mismatch");

    property p_lower_fires;
        s_lower_write |=> command_strobe
            && (command_axes == $past(cmd_upper[3:0]));
    endproperty
    a_lower_fires: assert property (p_lower_fires)
        else $error("lower command byte did not execute");

    property p_upper_waits;
        s_upper_write |=> !command_strobe;
    endproperty
    a_upper_waits: assert property (p_upper_waits)
        else $error("upper command byte executed early");

    property p_fields;
        cmd_fire |=> (command_code == $past(next_cmd_word[7:0]))
            && (command_axes == $past(next_cmd_word[11:8]));
    endproperty
    a_fields: assert property (p_fields)
        else $error("command fields misplaced");

    property p_lowest;
        (selected_axes != 4'h0) |-> selected_axes[pick_index]
            && ((selected_axes & ((4'h1 << pick_index) - 4'h1)) == 4'h0);
    endproperty
    a_lowest: assert property (p_lowest)
        else $error("not the lowest assigned axis");

endmodule

`default_nettype wire

// >>> include/mhra_pkg.sv
/*
  Package for the host register access block of a four-axis motion
  controller: read and write register indices, command codes, reset
  values and the packed carriers shared by the design files.
  Assumes a single 20 MHz clock and a synchronous active-high reset.
*/

package mhra_pkg;

    localparam int AXES = 4;
    localparam int PIN_WIDTH = 24;

    // Word indices on the host bus.
    localparam logic [2:0] IDX_MAIN = 3'h0;
    localparam logic [2:0] IDX_IRQ = 3'h1;
    localparam logic [2:0] IDX_ERR = 3'h2;
    localparam logic [2:0] IDX_PAGED = 3'h3;
    localparam logic [2:0] IDX_GPIO_XY = 3'h4;
    localparam logic [2:0] IDX_GPIO_ZU = 3'h5;
    localparam logic [2:0] IDX_DATA_LO = 3'h6;
    localparam logic [2:0] IDX_DATA_HI = 3'h7;
    localparam logic [2:0] IDX_CMD = 3'h0;

    // Command word fields.
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_AXES_LSB = 8;
    localparam logic [7:0] CMD_PAGE0 = 8'h7a;
    localparam logic [7:0] CMD_PAGE1 = 8'h7b;

    // Values after reset.
    localparam logic PAGE_RST = 1'b0;
    localparam logic [3:0] AXIS_SEL_RST = 4'h1;
    localparam logic [7:0] CMD_UPPER_RST = 8'h00;
    localparam logic [PIN_WIDTH-1:0] PINS_RST = 24'he0_0000;

    // Byte lane masks of a register write.
    localparam logic [1:0] LANE_LOW = 2'h1;
    localparam logic [1:0] LANE_HIGH = 2'h2;
    localparam logic [1:0] LANE_BOTH = 2'h3;

    typedef struct packed {
        logic [15:0] s3_page1;
        logic [15:0] s3_page0;
        logic [15:0] err_finish;
        logic [15:0] irq;
    } mhra_axis_status_s;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic bus8;
        logic [3:0] addr;
        logic [15:0] data;
    } mhra_pins_s;

endpackage

// >>> verilog/mhra_sync2.sv
/*
  Two-flop synchroniser for a bundle of host pins.
  Assumes each bit is an independent level; multi-bit words are only
  read after the strobe that frames them has settled.
*/
`timescale 1ns/1ns
`default_nettype none

module mhra_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VALUE = '0
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            meta <= RST_VALUE;
            q <= RST_VALUE;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end

endmodule

`default_nettype wire

// >>> verilog/mhra_axis_pick.sv
/*
  Picks the status set of one axis out of four.
  Assumes the axis mask comes from the last command naming an axis; an empty mask
  falls back to the X axis.
*/
`timescale 1ns/1ns
`default_nettype none

module mhra_axis_pick (
    input wire logic [3:0] axes,
    input wire mhra_pkg::mhra_axis_status_s [3:0] status,
    output logic [1:0] axis_index,
    output mhra_pkg::mhra_axis_status_s picked
);
    import mhra_pkg::*;

    always_comb
    begin
        axis_index = 2'h0;
        for (int i = AXES - 1; i >= 0; i--)
        begin
            if (axes[i])
            begin
                axis_index = 2'(i);
            end
        end
        picked = status[axis_index];
    end

endmodule

`default_nettype wire

// >>> test/mhra_host_model.sv
/*
  Host CPU model driving the parallel bus of the register access block.
  Assumes its tasks are called one at a time from the bench, and that
  the clock is the block's own system clock.
*/
`timescale 1ns/1ns
`default_nettype none

module mhra_host_model (
    input wire logic clock,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic bus8,
    output logic [3:0] addr,
    output logic [15:0] wr_data
);
    initial
    begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        bus8 = 1'b0;
        addr = 4'h0;
        wr_data = 16'h0000;
    end

    // Write: strobe low four cycles, data held until the strobe lands.
    task automatic bus_write(input logic b8, input logic [3:0] a,
        input logic [15:0] d);
    begin
        @(negedge clock);
        bus8 = b8;
        addr = a;
        wr_data = d;
        cs_n = 1'b0;
        wr_n = 1'b0;
        repeat (4) @(negedge clock);
        cs_n = 1'b1;
        wr_n = 1'b1;
        repeat (6) @(negedge clock);
        // A released data bus no longer shows the written value.
        wr_data = ~d;
    end
    endtask

    // Read: strobe held until the data enable is seen at a rising edge.
    task automatic bus_read(input logic b8, input logic [3:0] a,
        output logic [15:0] d);
    begin
        d = 16'hxxxx;
        @(negedge clock);
        bus8 = b8;
        addr = a;
        cs_n = 1'b0;
        rd_n = 1'b0;
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clock);
            if (rd_valid === 1'b1)
            begin
                d = rd_data;
                break;
            end
        end
        @(negedge clock);
        cs_n = 1'b1;
        rd_n = 1'b1;
        repeat (4) @(negedge clock);
    end
    endtask
endmodule

`default_nettype wire

// >>> test/tb_top.sv
/*
  Self-checking bench for the host register access block.
  Assumes the host model drives the pins and the bench drives the
  status inputs with fixed, distinct values.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    import mhra_pkg::*;

    typedef struct packed {
        logic do_cmd;
        logic [15:0] cmd;
        logic bus8;
        logic [3:0] addr;
        logic [15:0] exp;
    } mhra_row_s;

    logic clock;
    logic sys_rst;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic bus8;
    logic [3:0] addr;
    logic [15:0] wr_data;
    logic [15:0] host_data_out;
    logic host_data_oe;
    logic [15:0] main_status;
    mhra_axis_status_s [3:0] axis_status;
    logic [15:0] gpio_xy;
    logic [15:0] gpio_zu;
    logic [31:0] data_read_value;
    logic command_strobe;
    logic [7:0] command_code;
    logic [3:0] command_axes;
    logic reg_write_strobe;
    logic [2:0] reg_write_index;
    logic [15:0] reg_write_data;
    logic [1:0] reg_write_bytes;
    logic paged_status_page;
    logic [3:0] selected_axes;
    logic [15:0] rd;
    int num_errors = 0;
    int num_checks = 0;
    int cmd_count = 0;
    int wr_count = 0;
    int cycles = 0;
    int n;
    int m;

    // ---------------------------------------------------------------
    // Table of ordinary cases
    // ---------------------------------------------------------------
    mhra_row_s rows [16] = '{
        '{1'b0, 16'h0000, 1'b0, 4'h0, 16'h0a5c},
        '{1'b0, 16'h0000, 1'b0, 4'h1, 16'h1100},
        '{1'b0, 16'h0000, 1'b0, 4'h2, 16'h2200},
        '{1'b0, 16'h0000, 1'b0, 4'h3, 16'h3300},
        '{1'b0, 16'h0000, 1'b0, 4'h4, 16'h4455},
        '{1'b0, 16'h0000, 1'b0, 4'h5, 16'h6677},
        '{1'b0, 16'h0000, 1'b0, 4'h6, 16'hcdef},
        '{1'b0, 16'h0000, 1'b0, 4'h7, 16'h89ab},
        '{1'b1, 16'h0400, 1'b0, 4'h1, 16'h1102},
        '{1'b1, 16'h087b, 1'b0, 4'h3, 16'h4403},
        '{1'b1, 16'h067a, 1'b0, 4'h3, 16'h3301},
        '{1'b1, 16'h0000, 1'b0, 4'h2, 16'h2201},
        '{1'b0, 16'h0000, 1'b1, 4'h6, 16'h0001},
        '{1'b0, 16'h0000, 1'b1, 4'h7, 16'h0033},
        '{1'b0, 16'h0000, 1'b1, 4'hd, 16'h00cd},
        '{1'b0, 16'h0000, 1'b1, 4'h8, 16'h0055}
    };

    mhra_top u_mhra_top (
        .clock(clock),
        .sys_rst(sys_rst),
        .host_cs_n(cs_n),
        .host_rd_n(rd_n),
        .host_wr_n(wr_n),
        .bus8_mode(bus8),
        .host_addr(addr),
        .host_data_in(wr_data),
        .host_data_out(host_data_out),
        .host_data_oe(host_data_oe),
        .main_status(main_status),
        .axis_status(axis_status),
        .gpio_xy(gpio_xy),
        .gpio_zu(gpio_zu),
        .data_read_value(data_read_value),
        .command_strobe(command_strobe),
        .command_code(command_code),
        .command_axes(command_axes),
        .reg_write_strobe(reg_write_strobe),
        .reg_write_index(reg_write_index),
        .reg_write_data(reg_write_data),
        .reg_write_bytes(reg_write_bytes),
        .paged_status_page(paged_status_page),
        .selected_axes(selected_axes)
    );

    mhra_host_model u_mhra_host_model (
        .clock(clock),
        .rd_data(host_data_out),
        .rd_valid(host_data_oe),
        .cs_n(cs_n),
        .rd_n(rd_n),
        .wr_n(wr_n),
        .bus8(bus8),
        .addr(addr),
        .wr_data(wr_data)
    );

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cycles++;
        if (command_strobe === 1'b1)
            cmd_count++;
        if (reg_write_strobe === 1'b1)
            wr_count++;
        if (cycles == 4000)
        begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic check_val(input logic [15:0] seen,
        input logic [15:0] exp);
    begin
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    end
    endtask

    task automatic give_verdict();
    begin
        $display("checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask

    task automatic pulse_reset();
    begin
        @(negedge clock);
        sys_rst = 1'b1;
        repeat (3) @(negedge clock);
        sys_rst = 1'b0;
        @(posedge clock);
        #1;
        check_val({15'h0, paged_status_page}, 16'h0000);
        check_val({12'h0, selected_axes}, 16'h0001);
    end
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        sys_rst = 1'b1;
        main_status = 16'h0a5c;
        gpio_xy = 16'h4455;
        gpio_zu = 16'h6677;
        data_read_value = 32'h89ab_cdef;
        for (int a = 0; a < 4; a++)
            axis_status[a] = {16'h4400 + 16'(a), 16'h3300 + 16'(a),
                16'h2200 + 16'(a), 16'h1100 + 16'(a)};
        pulse_reset();
        for (int i = 0; i < 16; i++)
        begin
            if (rows[i].do_cmd)
            begin
                n = cmd_count;
                u_mhra_host_model.bus_write(1'b0, {1'b0, IDX_CMD},
                    rows[i].cmd);
                check_val(16'(cmd_count - n), 16'h0001);
                check_val({4'h0, command_axes, command_code},
                    {4'h0, rows[i].cmd[11:0]});
            end
            u_mhra_host_model.bus_read(rows[i].bus8, rows[i].addr, rd);
            check_val(rd, rows[i].exp);
        end
        // Byte-wide command: upper byte alone must not execute.
        n = cmd_count;
        m = wr_count;
        u_mhra_host_model.bus_write(1'b1, 4'h1, 16'h0008);
        check_val(16'(cmd_count - n + wr_count - m), 16'h0000);
        u_mhra_host_model.bus_write(1'b1, 4'h0, 16'h007b);
        check_val(16'(cmd_count - n), 16'h0001);
        check_val({4'h0, command_axes, command_code}, 16'h087b);
        check_val({15'h0, paged_status_page}, 16'h0001);
        u_mhra_host_model.bus_read(1'b1, 4'h6, rd);
        check_val(rd, 16'h0003);
        u_mhra_host_model.bus_read(1'b1, 4'h7, rd);
        check_val(rd, 16'h0044);
        // The data bus is released and cleared once a read is over.
        check_val(host_data_out, 16'h0000);
        check_val({15'h0, host_data_oe}, 16'h0000);
        // Other register writes are handed on, never executed.
        n = cmd_count;
        m = wr_count;
        u_mhra_host_model.bus_write(1'b0, 4'h4, 16'h1234);
        check_val(16'(wr_count - m), 16'h0001);
        check_val({13'h0, reg_write_index}, 16'h0004);
        check_val(reg_write_data, 16'h1234);
        check_val({14'h0, reg_write_bytes}, 16'h0003);
        u_mhra_host_model.bus_write(1'b1, 4'hb, 16'h00a5);
        check_val(16'(wr_count - m + cmd_count - n), 16'h0002);
        check_val({13'h0, reg_write_index}, 16'h0005);
        check_val(reg_write_data, 16'ha5a5);
        check_val({14'h0, reg_write_bytes}, 16'h0002);
        // Reset in mid-run drops the page back to zero.
        pulse_reset();
        u_mhra_host_model.bus_read(1'b0, 4'h3, rd);
        check_val(rd, 16'h3300);
        give_verdict();
    end
endmodule

`default_nettype wire
